// [core/mirror_defs.svh]
`ifndef MIRROR_DEFS_SVH
`define MIRROR_DEFS_SVH

// Positions in the image-select field
`define MIR_SEL_UID 0
`define MIR_SEL_CNT 1
`define MIR_SEL_TT 2

// Page numbers
`define MIR_MIN_PAGE 8'h03
`define MIR_TT_PAGE 8'h2D

// Byte indices into the page space (page * 4 + byte)
`define MIR_USER_END 11'h0A0

// Image lengths in ASCII characters
`define MIR_UID_LEN 10'h00E
`define MIR_CNT_LEN 10'h006
`define MIR_TT_LEN 10'h008
`define MIR_SEP_LEN 10'h001

// Separator character
`define MIR_SEP_CHAR 8'h78

// Reset value of the tamper message page
`define MIR_TT_RESET 32'h00000000

`endif

// [core/mirror_pkg.sv]
package mirror_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [9:0] index_t;
  typedef logic [2:0] image_sel_t;
endpackage : mirror_pkg

// [core/hex_digit.sv]
`timescale 1ns/1ps
module hex_digit (
  input wire logic [3:0] i_nibble,
  output logic [7:0] o_char
);
  // Upper-case digits only
  assign o_char = (i_nibble < 4'hA) ? (8'h30 + {4'h0, i_nibble})
                                    : (8'h37 + {4'h0, i_nibble});
endmodule : hex_digit

// [core/mirror_lane.sv]
`timescale 1ns/1ps
`include "mirror_defs.svh"
module mirror_lane #(
  parameter logic [1:0] LANE = 2'h0
) (
  input wire logic [7:0] i_page,
  input wire logic [9:0] i_start,
  input wire logic [9:0] i_cnt_at,
  input wire logic [9:0] i_tt_at,
  input wire logic i_active,
  input wire logic i_uid_on,
  input wire logic i_cnt_on,
  input wire logic i_tt_on,
  input wire logic i_cnt_show,
  input wire logic i_tt_show,
  input wire logic [55:0] i_uid,
  input wire logic [23:0] i_counter,
  input wire logic [31:0] i_tt_msg,
  input wire logic [7:0] i_stored,
  output logic [7:0] o_byte
);
  wire [9:0] idx = {i_page, LANE};
  wire in_span = i_active && (idx >= i_start);
  wire [9:0] rel = idx - i_start;
  wire [9:0] cnt_rel = rel - i_cnt_at;
  wire [9:0] tt_rel = rel - i_tt_at;

  wire uid_hit = i_uid_on && (rel < `MIR_UID_LEN);
  wire cnt_hit = i_cnt_on && (rel >= i_cnt_at) && (cnt_rel < `MIR_CNT_LEN);
  wire tt_hit = i_tt_on && (rel >= i_tt_at) && (tt_rel < `MIR_TT_LEN);

  wire sep_hit = (i_uid_on && (i_cnt_on || i_tt_on) && (rel == `MIR_UID_LEN)) ||
                 (i_cnt_on && i_tt_on && (rel == i_cnt_at + `MIR_CNT_LEN));

  // source bytes in order, most significant first
  wire [55:0] uid_sh = i_uid << {rel[3:1], 3'b000};
  wire [23:0] cnt_sh = i_counter << {cnt_rel[2:1], 3'b000};
  // tamper source is the stored message page
  wire [31:0] tt_sh = i_tt_msg << {tt_rel[2:1], 3'b000};

  wire [7:0] src = uid_hit ? uid_sh[55:48] : (cnt_hit ? cnt_sh[23:16] : tt_sh[31:24]);
  wire lo_half = uid_hit ? rel[0] : (cnt_hit ? cnt_rel[0] : tt_rel[0]);
  wire [3:0] nib = lo_half ? src[3:0] : src[7:4];
  wire [7:0] ch;

  hex_digit u_hex (
    .i_nibble(nib),
    .o_char(ch)
  );

  // hidden images fall back to stored bytes
  assign o_byte = !in_span ? i_stored :
                  sep_hit ? `MIR_SEP_CHAR :
                  uid_hit ? ch :
                  cnt_hit ? (i_cnt_show ? ch : i_stored) :
                  tt_hit ? (i_tt_show ? ch : i_stored) : i_stored;
endmodule : mirror_lane

// [core/ascii_mirror_read_overlay.sv]
// Operation
// - Serial number can appear as fourteen ASCII bytes without changing memory.
// - Reads over serial image positions return the ASCII image bytes.
// - Start page plus start byte give the position of the first image.
// - Serial image active only with start page above 03h and selected.
// - Three-byte read counter can appear as a six-byte ASCII image.
// - Reads over counter image positions return the current counter in ASCII.
// - Counter image starts at the start position, or after the serial image.
// - Counter image active only with start page above 03h and selected.
// - With counter read protection set, counter image needs session password success.
// - Tamper message appears as eight ASCII bytes only after latched open wire.
// - Without a latched tamper event, tamper positions return stored bytes.
// - Tamper image source is the four-byte configuration page 2Dh.
// - Tamper image follows whichever earlier images are enabled.
// - Tamper image active only with start page above 03h and selected.
// - One 78h separator byte sits between adjacent active images.
// - Images running past user memory end are not substituted at all.
// - Image select field chooses serial, counter and tamper images.
`timescale 1ns/1ps
`include "mirror_defs.svh"
module ascii_mirror_read_overlay (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [7:0] i_mirror_page,
  input wire logic [1:0] i_mirror_byte,
  input wire mirror_pkg::image_sel_t i_image_select,
  input wire logic i_counter_read_protect,
  input wire logic i_auth_ok,
  input wire logic i_tamper_enable,
  input wire logic i_tamper_latched,
  input wire logic [55:0] i_uid,
  input wire logic [23:0] i_counter,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_page,
  input wire logic [31:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_page,
  input wire logic [31:0] i_rd_data,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data
);
  logic [31:0] tamper_message_r;
  logic [31:0] rd_data_nxt;
  logic rd_valid_r;
  logic [31:0] rd_data_r;

  wire uid_on = i_image_select[`MIR_SEL_UID];
  wire cnt_on = i_image_select[`MIR_SEL_CNT];
  wire tt_on = i_image_select[`MIR_SEL_TT];

  wire [9:0] start = {i_mirror_page, i_mirror_byte};

  // counter follows serial image and its separator
  wire [9:0] cnt_at = uid_on ? (`MIR_UID_LEN + `MIR_SEP_LEN) : 10'h000;
  // tamper follows the earlier enabled images
  wire [9:0] tt_at = cnt_on ? (cnt_at + `MIR_CNT_LEN + `MIR_SEP_LEN) :
                     (uid_on ? (`MIR_UID_LEN + `MIR_SEP_LEN) : 10'h000);
  wire [9:0] total = tt_on ? (tt_at + `MIR_TT_LEN) :
                     (cnt_on ? (cnt_at + `MIR_CNT_LEN) :
                     (uid_on ? `MIR_UID_LEN : 10'h000));

  // whole span must end inside user memory
  wire [10:0] span_end = {1'b0, start} + {1'b0, total};
  wire fits = span_end <= `MIR_USER_END;

  // mirroring needs a start page above 03h
  wire active = (i_mirror_page > `MIR_MIN_PAGE) && fits && (uid_on || cnt_on || tt_on);

  // protected counter only after password success
  wire cnt_show = !i_counter_read_protect || i_auth_ok;
  // tamper image only after a latched open wire
  wire tt_show = i_tamper_enable && i_tamper_latched;

  wire [31:0] overlay;
  // Message page reads as zero while tamper detection is armed
  wire [31:0] tt_page_view = i_tamper_enable ? 32'h00000000 : tamper_message_r;
  wire tt_page_sel = i_rd_page == `MIR_TT_PAGE;
  wire tt_page_wr = i_wr_en && (i_wr_page == `MIR_TT_PAGE);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      // stored bytes untouched, substitution on the read path only
      mirror_lane #(.LANE(2'(g))) u_lane (
        .i_page(i_rd_page),
        .i_start(start),
        .i_cnt_at(cnt_at),
        .i_tt_at(tt_at),
        .i_active(active),
        .i_uid_on(uid_on),
        .i_cnt_on(cnt_on),
        .i_tt_on(tt_on),
        .i_cnt_show(cnt_show),
        .i_tt_show(tt_show),
        .i_uid(i_uid),
        .i_counter(i_counter),
        .i_tt_msg(tamper_message_r),
        .i_stored(i_rd_data[31 - 8 * g -: 8]),
        .o_byte(overlay[31 - 8 * g -: 8])
      );
    end
  endgenerate

  assign rd_data_nxt = tt_page_sel ? tt_page_view : overlay;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tamper_message_r <= `MIR_TT_RESET;
    end else if (i_ce && tt_page_wr) begin
      tamper_message_r <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 32'h00000000;
    end else if (i_ce) begin
      rd_valid_r <= i_rd_en;
      if (i_rd_en) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign o_rd_valid = rd_valid_r;
  assign o_rd_data = rd_data_r;
endmodule : ascii_mirror_read_overlay

// [tb/overlay_asserts.sv]
`timescale 1ns/1ps
module overlay_asserts (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [7:0] i_mirror_page,
  input wire mirror_pkg::image_sel_t i_image_select,
  input wire logic i_tamper_enable,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_page,
  input wire logic [31:0] i_rd_data,
  input wire logic o_rd_valid,
  input wire logic [31:0] o_rd_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence take;
    i_ce && i_rd_en;
  endsequence
  // Page 2Dh is answered from the message register, not the stored data
  sequence plain;
    take ##0 i_rd_page != 8'h2D;
  endsequence
  a_valid_after_read: assert property (take |=> o_rd_valid)
    else $error("read not answered");
  a_valid_one_shot: assert property (i_ce && !i_rd_en |=> !o_rd_valid)
    else $error("valid without read");
  a_freeze_no_ce: assert property (!i_ce |=> $stable(o_rd_valid) && $stable(o_rd_data))
    else $error("outputs moved without enable");
  a_low_page_plain: assert property (plain ##0 i_mirror_page <= 8'h03 |=>
    o_rd_data == $past(i_rd_data)) else $error("overlay below page 04h");
  a_no_select_plain: assert property (plain ##0 i_image_select == 3'h0 |=>
    o_rd_data == $past(i_rd_data)) else $error("overlay with no image");
  a_overrun_plain: assert property (plain ##0 i_mirror_page > 8'h26 |=>
    o_rd_data == $past(i_rd_data)) else $error("overlay past memory end");
  a_before_start: assert property (plain ##0 i_rd_page < i_mirror_page |=>
    o_rd_data == $past(i_rd_data)) else $error("overlay before start");
  a_msg_masked: assert property (take ##0 i_rd_page == 8'h2D && i_tamper_enable |=>
    o_rd_data == 32'h0) else $error("message page not masked");
endmodule : overlay_asserts
bind ascii_mirror_read_overlay overlay_asserts i_chk (.*);

// [tb/mem_model.sv]
`timescale 1ns/1ps
module mem_model (
  input wire logic [7:0] i_page,
  output logic [31:0] o_data
);
  // Every page differs so a missing or misplaced overlay byte shows
  assign o_data = {i_page, ~i_page, i_page ^ 8'h5A, 8'hC3};
endmodule : mem_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [2:0] s; logic [7:0] pg; logic [1:0] by; logic [3:0] f;} row_s;
  logic i_clk = 0, i_nrst = 0, i_ce = 1, i_counter_read_protect = 0, i_auth_ok = 0;
  logic i_tamper_enable = 0, i_tamper_latched = 0, i_wr_en = 0, i_rd_en = 0, o_rd_valid;
  logic [7:0] i_mirror_page = 0, i_wr_page = 0, i_rd_page = 0;
  logic [1:0] i_mirror_byte = 0;
  mirror_pkg::image_sel_t i_image_select = 0;
  logic [31:0] i_wr_data = 0, i_rd_data, o_rd_data, msg = 32'hA023CD1B;
  // Serial number value is arbitrary
  logic [55:0] i_uid = 56'h0123456789ABCD;
  // reader has set counter enable, so a counting value is supplied
  logic [23:0] i_counter = 24'h003F31;
  logic act = 0;
  logic [8:0] img[$];
  int n_errors = 0, n_tests = 0, cyc = 0;
  row_s rows [15] = '{'{1, 12, 1, 3}, '{2, 12, 1, 3}, '{3, 12, 1, 3}, '{4, 12, 1, 3},
    '{5, 12, 1, 3}, '{6, 12, 1, 3}, '{7, 12, 1, 3}, '{7, 12, 1, 8}, '{7, 12, 1, 15},
    '{7, 12, 0, 2}, '{7, 3, 1, 3}, '{1, 36, 2, 3}, '{6, 37, 0, 3}, '{7, 36, 3, 3},
    '{7, 39, 0, 3}};
  always #5 i_clk = ~i_clk;
  mem_model i_mem (.i_page(i_rd_page), .o_data(i_rd_data));
  ascii_mirror_read_overlay i_dut (.*);
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  task automatic push(input logic [63:0] v, input int n, input logic show);
    if (img.size() != 0) img.push_back(9'h078);
    for (int k = n - 1; k >= 0; k--) img.push_back(show ? {1'b0, hx(v[4*k +: 4])} : 9'h100);
  endtask : push
  function automatic logic [31:0] expw(input logic [7:0] p);
    logic [31:0] s;
    int off;
    s = {p, ~p, p ^ 8'h5A, 8'hC3};
    for (int b = 0; b < 4; b++) begin
      off = {p, 2'h0} + b - {i_mirror_page, i_mirror_byte};
      if (act && off >= 0 && off < img.size() && img[off] != 9'h100) begin
        s[31-8*b -: 8] = img[off][7:0];
      end
    end
    return s;
  endfunction : expw
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] p, input logic [31:0] e);
    @(negedge i_clk);
    i_rd_en = 1;
    i_rd_page = p;
    @(negedge i_clk);
    i_rd_en = 0;
    chk("valid", 1, o_rd_valid);
    chk("data", e, o_rd_data);
  endtask : rd
  task automatic wr(input logic [7:0] p, input logic [31:0] d);
    @(negedge i_clk);
    {i_wr_en, i_wr_page, i_wr_data} = {1'b1, p, d};
    @(negedge i_clk);
    i_wr_en = 0;
  endtask : wr
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_nrst = 1;
    chk("reset data", 0, o_rd_data);
    rd(8'h2D, 0);
    wr(8'h2D, msg);
    wr(8'h2C, 32'hFFFFFFFF);
    rd(8'h2D, msg);
    $display("message page done");
    foreach (rows[i]) begin
      @(negedge i_clk);
      {i_image_select, i_mirror_page, i_mirror_byte} = {rows[i].s, rows[i].pg, rows[i].by};
      {i_counter_read_protect, i_auth_ok, i_tamper_enable, i_tamper_latched} = rows[i].f;
      img.delete();
      if (rows[i].s[0]) push(i_uid, 14, 1);
      if (rows[i].s[1]) push(i_counter, 6, !rows[i].f[3] || rows[i].f[2]);
      if (rows[i].s[2]) push(msg, 8, rows[i].f[1] && rows[i].f[0]);
      act = rows[i].pg > 8'h03 && {rows[i].pg, rows[i].by} + img.size() <= 11'h0A0;
      for (int p = 4; p < 40; p++) rd(p[7:0], expw(p[7:0]));
      $display("row %0d done", i);
    end
    rd(8'h2D, 0);
    @(negedge i_clk);
    {i_ce, i_rd_en, i_rd_page} = {2'b11, 8'h10};
    @(negedge i_clk);
    {i_ce, i_rd_page} = {1'b0, 8'h11};
    chk("read before freeze", expw(8'h10), o_rd_data);
    @(negedge i_clk);
    chk("frozen valid", 1, o_rd_valid);
    chk("frozen data", expw(8'h10), o_rd_data);
    {i_ce, i_rd_page} = {1'b1, 8'h12};
    @(negedge i_clk);
    i_rd_page = 8'h13;
    chk("burst first", expw(8'h12), o_rd_data);
    @(negedge i_clk);
    i_nrst = 0;
    chk("burst second", expw(8'h13), o_rd_data);
    @(negedge i_clk);
    {i_nrst, i_rd_en} = 2'b10;
    chk("second reset valid", 0, o_rd_valid);
    chk("second reset data", 0, o_rd_data);
    $display("awkward cases done");
    complete_run;
  end
endmodule : testbench
